// ==== hw/itnp_pkg.sv ====
// constants and rule summary for the i2c target with shadow sram and eeprom
// Summary of operation
// R01: target at 100 kHz and 1 MHz
// R02: ignore pin pulses under 50 ns
// R03: answer only target address 1011001
// R04: sda changes only while scl low
// R05: controller makes start and stop; detect both
// R06: eight bits msb first plus acknowledge
// R07: acknowledge low on ninth pulse, nack high
// R08: ack own address, else idle till start
// R09: nack on read ends transfer, release sda
// R10: controller stops after last write ack
// R11: pointer byte then data, pointer increments
// R12: repeated start read returns successive registers
// R13: control bit 6 copies registers to sram
// R14: sram data writes store at successive addresses
// R15: host writes base array plus one page
// R16: busy bit 2 set, eeprom refused meanwhile
// R17: host writes unlock key before programming
// R18: control bit 0 programs sram into eeprom
// R19: count increments per completed programming cycle
// R20: host relocks key with zero afterward
// R21: sram data reads return then advance address
// R22: eeprom data reads return then advance address
// R23: host avoids back to back address writes
// R24: power up loads eeprom into registers
// R25: read only bits ignore writes
// R26: programming ignored unless key unlocked
`default_nettype none
package itnp_pkg;
    // ==========================================================
    // link
    localparam logic [6:0] TARGET_ADDR     = 7'h59;
    localparam int         CLK_PERIOD_NS   = 100;
    localparam int         GLITCH_NS       = 50;
    // least filter time rounds up, never below one cycle
    localparam int         GLITCH_CYC_RAW  = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         GLITCH_CYC      = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_PROG_COUNT  = 8'h30;
    localparam logic [7:0] OFS_MEM_CTRL    = 8'h31;
    localparam logic [7:0] OFS_MEM_ADDR    = 8'h33;
    localparam logic [7:0] OFS_EE_RDATA    = 8'h34;
    localparam logic [7:0] OFS_SRAM_DATA   = 8'h35;
    localparam logic [7:0] OFS_UNLOCK      = 8'h38;
    // ==========================================================
    // fields and values
    localparam int         CTRL_COPY_BIT   = 6;
    localparam int         CTRL_BUSY_BIT   = 2;
    localparam int         CTRL_PROG_BIT   = 0;
    localparam logic [7:0] UNLOCK_VALUE    = 8'hbe;
    localparam logic [7:0] RESET_ZERO      = 8'h00;
    localparam int         MEM_DEPTH       = 64;
    localparam int         PROG_CYCLES     = 64;
endpackage : itnp_pkg
`default_nettype wire

// ==== hw/itnp_target.sv ====
// i2c target with register file, shadow sram and eeprom programming engine
`timescale 1ns/100ps
`default_nettype none
module itnp_target
    import itnp_pkg::*;
#(
    parameter int DEPTH      = MEM_DEPTH,
    parameter int PROG_TICKS = PROG_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic sda_out,
    output var  logic sda_oe,
    output var  logic busy
);
    localparam int AW = $clog2(DEPTH);
    typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK} itnp_state_e;

    // ==========================================================
    // storage: live registers, shadow sram, non-volatile array
    logic [7:0] regs_r  [DEPTH];
    logic [7:0] sram_r  [DEPTH];
    logic [7:0] eeprom_r[DEPTH];

    // ==========================================================
    // pin synchronisers then glitch filter
    logic [1:0] scl_sync_r, sda_sync_r;
    logic       scl_f_r, sda_f_r, scl_q_r, sda_q_r;
    logic [3:0] scl_cnt_r, sda_cnt_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
        end
    end

    // a level must hold past the glitch time before it is believed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_f_r   <= 1'b1;
            sda_f_r   <= 1'b1;
            scl_cnt_r <= 4'h0;
            sda_cnt_r <= 4'h0;
        end else begin
            if (scl_sync_r[1] == scl_f_r) scl_cnt_r <= 4'h0;
            else if (scl_cnt_r >= 4'(GLITCH_CYC)) begin // R02
                scl_f_r   <= scl_sync_r[1];
                scl_cnt_r <= 4'h0;
            end else scl_cnt_r <= scl_cnt_r + 4'h1;
            if (sda_sync_r[1] == sda_f_r) sda_cnt_r <= 4'h0;
            else if (sda_cnt_r >= 4'(GLITCH_CYC)) begin // R02
                sda_f_r   <= sda_sync_r[1];
                sda_cnt_r <= 4'h0;
            end else sda_cnt_r <= sda_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_f_r;
            sda_q_r <= sda_f_r;
        end
    end

    // edge and condition detection; rates up to 1 MHz leave ample samples
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_f_r & ~scl_q_r;                  // R01
    assign scl_fall = ~scl_f_r & scl_q_r;
    assign start_c  = scl_f_r & scl_q_r & sda_q_r & ~sda_f_r;  // R05
    assign stop_c   = scl_f_r & scl_q_r & ~sda_q_r & sda_f_r;  // R05

    // ==========================================================
    // protocol state
    itnp_state_e state_r;
    logic [7:0]  shift_r;
    logic [2:0]  bit_r;
    logic        rw_r, have_ptr_r, nack_r, addr_full_r;
    logic [7:0]  ptr_r, mem_addr_r, unlock_r, count_r, ctrl_r;
    logic        prog_busy_r, boot_r;
    logic [15:0] prog_cnt_r;
    logic [AW:0] boot_idx_r;

    // read data for a given pointer; used for first and later bytes
    function automatic logic [7:0] rd_val(input logic [7:0] a);
        case (a)
            OFS_PROG_COUNT: rd_val = count_r;
            OFS_MEM_CTRL:   rd_val = {ctrl_r[7:3], prog_busy_r, ctrl_r[1:0]};  // R16
            OFS_MEM_ADDR:   rd_val = mem_addr_r;
            OFS_EE_RDATA:   rd_val = prog_busy_r ? RESET_ZERO : eeprom_r[AW'(mem_addr_r)]; // R16 R22
            OFS_SRAM_DATA:  rd_val = sram_r[AW'(mem_addr_r)];                           // R21
            OFS_UNLOCK:     rd_val = unlock_r;
            default:        rd_val = (a < 8'(DEPTH)) ? regs_r[AW'(a)] : RESET_ZERO;
        endcase
    endfunction : rd_val

    // one decoded read byte; bits are picked from this net, not from the call
    logic [7:0] rd_byte;
    assign rd_byte = rd_val(ptr_r);

    logic wr_byte_done;
    logic rd_byte_load;
    assign wr_byte_done = (state_r == ST_WR) && scl_rise && (bit_r == 3'h7) && have_ptr_r;
    assign rd_byte_load = scl_fall && ((state_r == ST_ADDR_ACK && rw_r) ||
                                       (state_r == ST_RD_ACK && !nack_r));

    // byte engine: msb first, nine pulses per byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= ST_IDLE;
            shift_r    <= 8'h00;
            bit_r      <= 3'h0;
            rw_r       <= 1'b0;
            have_ptr_r <= 1'b0;
            nack_r     <= 1'b0;
            addr_full_r <= 1'b0;
            ptr_r      <= 8'h00;
            sda_out    <= 1'b1;
            sda_oe     <= 1'b0;
        end else if (start_c) begin
            state_r    <= ST_ADDR;
            bit_r      <= 3'h0;
            have_ptr_r <= 1'b0;
            sda_oe     <= 1'b0;
            addr_full_r <= 1'b0;
        end else if (stop_c) begin
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: sda_oe <= 1'b0;
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_f_r};  // R06
                        bit_r   <= bit_r + 3'h1;
                        if (bit_r == 3'h7) addr_full_r <= 1'b1;
                    end else if (scl_fall && addr_full_r) begin
                        // only a full byte is judged; the fall right after start is not
                        addr_full_r <= 1'b0;
                        if (shift_r[7:1] == TARGET_ADDR) begin  // R03 R08
                            rw_r    <= shift_r[0];
                            sda_out <= 1'b0;                   // R07
                            sda_oe  <= 1'b1;
                            state_r <= ST_ADDR_ACK;
                        end else state_r <= ST_IDLE;           // R08
                    end
                end
                ST_ADDR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        // change sda only with scl low
                        if (rd_byte_load) begin              // R04 R12
                            shift_r <= {rd_byte[6:0], 1'b0};
                            sda_out <= rd_byte[7];
                            sda_oe  <= 1'b1;
                            state_r <= ST_RD;
                        end else begin
                            sda_oe  <= 1'b0;
                            state_r <= ST_WR;
                        end
                        bit_r <= 3'h0;
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_f_r};
                        bit_r   <= bit_r + 3'h1;
                        if (bit_r == 3'h7) begin
                            if (!have_ptr_r) begin             // R11
                                ptr_r      <= {shift_r[6:0], sda_f_r};
                                have_ptr_r <= 1'b1;
                            end else ptr_r <= ptr_r + 8'h1;    // R11
                        end
                    end else if (scl_fall && bit_r == 3'h0) begin
                        sda_out <= 1'b0;                       // R07 R11
                        sda_oe  <= 1'b1;
                        state_r <= ST_WR_ACK;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'h7) begin
                            sda_oe  <= 1'b0;                   // release for ack
                            ptr_r   <= ptr_r + 8'h1;           // R12
                            state_r <= ST_RD_ACK;
                        end else begin
                            sda_out <= shift_r[7];             // R04 R06
                            shift_r <= {shift_r[6:0], 1'b0};
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) nack_r <= sda_f_r;
                    else if (scl_fall) begin
                        if (nack_r) begin
                            sda_oe  <= 1'b0;                   // R09
                            state_r <= ST_IDLE;
                        end else begin
                            shift_r <= {rd_byte[6:0], 1'b0};
                            sda_out <= rd_byte[7];
                            sda_oe  <= 1'b1;
                            bit_r   <= 3'h0;
                            state_r <= ST_RD;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // register writes, memory access port and programming engine
    logic [7:0] wdata;
    logic       wr_now, rd_now;
    assign wdata  = {shift_r[6:0], sda_f_r};
    assign wr_now = wr_byte_done;
    assign rd_now = (state_r == ST_RD) && scl_fall && (bit_r == 3'h7);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_addr_r  <= 8'h00;
            unlock_r    <= RESET_ZERO;
            count_r     <= RESET_ZERO;
            ctrl_r      <= RESET_ZERO;
            prog_busy_r <= 1'b0;
            prog_cnt_r  <= 16'h0000;
            boot_r      <= 1'b1;
            boot_idx_r  <= '0;
        end else begin
            ctrl_r[CTRL_COPY_BIT] <= 1'b0;   // self clearing strobes
            ctrl_r[CTRL_PROG_BIT] <= 1'b0;
            if (boot_r) begin                 // R24
                regs_r[AW'(boot_idx_r)] <= eeprom_r[AW'(boot_idx_r)];
                boot_idx_r <= boot_idx_r + 1'b1;
                if (boot_idx_r == (AW+1)'(DEPTH - 1)) boot_r <= 1'b0;
            end
            if (prog_busy_r) begin
                if (prog_cnt_r == 16'(PROG_TICKS - 1)) begin
                    for (int i = 0; i < DEPTH; i++) eeprom_r[i] <= sram_r[i];  // R18
                    prog_busy_r <= 1'b0;
                    count_r     <= count_r + 8'h1;     // R19
                end else prog_cnt_r <= prog_cnt_r + 16'h1;
            end
            if (rd_now && (ptr_r == OFS_SRAM_DATA || ptr_r == OFS_EE_RDATA))
                mem_addr_r <= mem_addr_r + 8'h1;      // R21 R22
            if (wr_now) begin
                case (ptr_r)
                    OFS_PROG_COUNT, OFS_EE_RDATA: ;   // R25
                    OFS_MEM_ADDR:  mem_addr_r <= wdata;
                    OFS_UNLOCK:    unlock_r   <= wdata;
                    OFS_SRAM_DATA: begin              // R14
                        sram_r[AW'(mem_addr_r)] <= wdata;
                        mem_addr_r <= mem_addr_r + 8'h1;
                    end
                    OFS_MEM_CTRL: begin
                        ctrl_r <= {wdata[7:3], 1'b0, wdata[1:0]};  // R25
                        if (wdata[CTRL_COPY_BIT] && !prog_busy_r)  // R13
                            for (int i = 0; i < DEPTH; i++) sram_r[i] <= regs_r[i];
                        if (wdata[CTRL_PROG_BIT] && unlock_r == UNLOCK_VALUE && !prog_busy_r) begin // R26
                            prog_busy_r <= 1'b1;                   // R16
                            prog_cnt_r  <= 16'h0000;
                        end
                    end
                    default: if (ptr_r < 8'(DEPTH)) regs_r[AW'(ptr_r)] <= wdata;
                endcase
            end
        end
    end

    // busy flag out of its own flop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) busy <= 1'b0;
        else busy <= prog_busy_r;
    end

    // marks that the array holds programmed content; kept through reset like the array
    logic ee_valid_r;
    always_ff @(posedge clk) begin
        if (prog_busy_r && prog_cnt_r == 16'(PROG_TICKS - 1)) ee_valid_r <= 1'b1;
    end

    // ==========================================================
    // checks
    AST_ACK_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == ST_ADDR && scl_fall && addr_full_r && shift_r[7:1] == TARGET_ADDR)
        |=> (sda_oe && !sda_out)) else $error("address not acknowledged"); // R08
    AST_FOREIGN: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == ST_ADDR && scl_fall && addr_full_r && shift_r[7:1] != TARGET_ADDR && !start_c && !stop_c)
        |=> (state_r == ST_IDLE && !sda_oe)) else $error("foreign address answered"); // R03
    AST_STABLE: assert property (@(posedge clk) disable iff (!rst_b)
        (scl_f_r && scl_q_r && !start_c && !stop_c) |=> $stable(sda_out) || !scl_q_r)
        else $error("sda moved with scl high"); // R04
    AST_NACK_END: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == ST_RD_ACK && nack_r && scl_fall && !start_c && !stop_c) |=> !sda_oe && state_r == ST_IDLE)
        else $error("sda held after nack"); // R09
    AST_BUSY: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(prog_busy_r) |-> (prog_busy_r [*8])) else $error("busy dropped early"); // R16
    AST_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(prog_busy_r) |-> count_r == $past(count_r) + 8'h1) else $error("count not bumped"); // R19
    AST_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_now && ptr_r == OFS_MEM_CTRL && unlock_r != UNLOCK_VALUE && !prog_busy_r) |=> !prog_busy_r)
        else $error("programmed while locked"); // R26
    AST_RO: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_now && ptr_r == OFS_PROG_COUNT && !prog_busy_r) |=> $stable(count_r)) else $error("count written"); // R25
    AST_SRAM_INC: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_now && ptr_r == OFS_SRAM_DATA) |=> mem_addr_r == $past(mem_addr_r) + 8'h1)
        else $error("sram address not advanced"); // R14
    AST_BOOT: assert property (@(posedge clk) disable iff (!rst_b)
        ($fell(boot_r) && ee_valid_r) |-> regs_r[0] == eeprom_r[0]) else $error("boot load missing"); // R24
endmodule : itnp_target
`default_nettype wire

// ==== test/itnp_ctrl_model.sv ====
// i2c bus controller model that drives the target's link pins
`timescale 1ns/100ps
`default_nettype none
module itnp_ctrl_model (
    input  wire logic clk,
    output var  logic scl,
    output var  logic sda_low,
    input  wire logic sda
);
    // ==========================================================
    // bus phases
    int slow_ticks = 0; // extra low-phase cycles to act as a slow controller
    logic spike = 1'b0; // when set, a sub-filter scl pulse lands in the low phase of every bit
    // idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // pins move just after a clock edge, never on it; only the spike's rise lands mid-cycle
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // data moves only while scl is low; the long low phase covers the target's input latency
    task automatic bit_io(input logic b, output logic seen);
        tick(2 + slow_ticks);
        sda_low = !b;
        // 40 ns pulse straddling a clock edge, which the target must not count
        if (spike) begin
            #60 scl = 1'b1;
            #40 scl = 1'b0;
        end
        tick(4);
        scl = 1'b1;
        tick(1);
        seen = sda;
        tick(1);
        scl = 1'b0;
    endtask : bit_io
    // start and repeated start both come from here
    task automatic start_cond();
        tick(2 + slow_ticks);
        sda_low = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask : start_cond
    // stop right after the last ack pulse
    task automatic stop_cond();
        tick(2 + slow_ticks);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask : stop_cond
    // eight bits msb first, then the receiver's ack pulse
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : send_byte
    // last byte of a read is left unacknowledged
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask : recv_byte
endmodule : itnp_ctrl_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench for the i2c target with shadow sram and eeprom
`timescale 1ns/100ps
`default_nettype none
module tb;
    import itnp_pkg::*;
    // ==========================================================
    // setup
    localparam int PT = 1500; // long enough to watch busy over the link
    logic       clk, rst_b, scl, sda_low, sda_out, sda_oe, busy, sda, a;
    logic [7:0] img [8];
    logic [7:0] tx  [8];
    logic [7:0] rb  [8];
    logic [7:0] c1;
    int         fails = 0;
    int         compares = 0;
    int         seed = 32'h02fe87d3;
    assign sda = !(sda_low || (sda_oe && !sda_out)); // pulled-up open-drain line
    itnp_target #(.DEPTH(MEM_DEPTH), .PROG_TICKS(PT)) i_itnp_target (.clk(clk), .rst_b(rst_b),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
    itnp_ctrl_model m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));
    initial clk = 1'b0;
    always #50 clk = ~clk;
    // ==========================================================
    // helpers
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8
    task automatic wrap_up();
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // (repeated) start, own address with write bit, then the pointer byte
    task automatic hdr(input logic [7:0] p);
        m.start_cond();
        m.send_byte({TARGET_ADDR, 1'b0}, a);
        chk8("addr ack", 8'h01, {7'h00, a});
        m.send_byte(p, a);
        chk8("ptr ack", 8'h01, {7'h00, a});
    endtask : hdr
    task automatic wr(input logic [7:0] p, input int n);
        hdr(p);
        for (int i = 0; i < n; i++) begin
            m.send_byte(tx[i], a);
            chk8("data ack", 8'h01, {7'h00, a});
        end
        m.stop_cond();
    endtask : wr
    task automatic rd(input logic [7:0] p, input int n);
        hdr(p);
        m.start_cond();
        m.send_byte({TARGET_ADDR, 1'b1}, a);
        chk8("read ack", 8'h01, {7'h00, a});
        for (int i = 0; i < n; i++) m.recv_byte(i == n - 1, rb[i]);
        repeat (8) @(posedge clk);
        #1;
        chk8("released", 8'h00, {7'h00, sda_oe});
        m.stop_cond();
    endtask : rd
    task automatic w1(input logic [7:0] p, input logic [7:0] d);
        tx[0] = d;
        wr(p, 1);
    endtask : w1
    // one address write per transaction, then indexed data accesses
    task automatic mem(input logic [7:0] port, input logic [7:0] ad, input int n, input logic w);
        hdr(OFS_MEM_ADDR);
        m.send_byte(ad, a);
        for (int k = 0; k < n; k++) begin
            hdr(port);
            if (w) begin
                m.send_byte(tx[k], a);
            end else begin
                m.start_cond();
                m.send_byte({TARGET_ADDR, 1'b1}, a);
                m.recv_byte(1'b1, rb[k]);
            end
        end
        m.stop_cond();
    endtask : mem
    task automatic wait_idle();
        int t;
        t = 0;
        while (busy !== 1'b0 && t < 3000) begin
            @(posedge clk);
            t++;
        end
        #1;
        chk8("busy end", 8'h00, {7'h00, busy});
    endtask : wait_idle
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (120) @(posedge clk); // boot copy runs first
        #1;
    endtask : do_reset
    // ==========================================================
    // main sequence
    initial begin
        do_reset();
        // a foreign address gets no acknowledge
        m.start_cond();
        m.send_byte({TARGET_ADDR ^ 7'h01, 1'b0}, a);
        chk8("foreign ack", 8'h00, {7'h00, a});
        m.stop_cond();
        // random block write, read back with repeated start
        for (int i = 0; i < 8; i++) img[i] = 8'($random(seed));
        tx = img;
        m.spike = 1'b1;
        wr(8'h00, 8);
        m.spike = 1'b0;
        rd(8'h00, 8);
        for (int i = 0; i < 8; i++) chk8("reg", img[i], rb[i]);
        // register image into sram, read back by index
        w1(OFS_MEM_CTRL, 8'h40);
        mem(OFS_SRAM_DATA, 8'h00, 8, 1'b0);
        for (int i = 0; i < 8; i++) chk8("sram copy", img[i], rb[i]);
        // overwrite a slice of sram by index
        for (int i = 0; i < 4; i++) tx[i] = 8'($random(seed));
        for (int i = 0; i < 4; i++) img[i + 2] = tx[i];
        mem(OFS_SRAM_DATA, 8'h02, 4, 1'b1);
        mem(OFS_SRAM_DATA, 8'h00, 8, 1'b0);
        for (int i = 0; i < 8; i++) chk8("sram write", img[i], rb[i]);
        // a program request with the key locked does nothing
        w1(OFS_UNLOCK, 8'h00);
        w1(OFS_MEM_CTRL, 8'h01);
        chk8("locked busy", 8'h00, {7'h00, busy});
        // unlocked programming: busy shows, eeprom is refused
        w1(OFS_UNLOCK, UNLOCK_VALUE);
        w1(OFS_MEM_CTRL, 8'h01);
        chk8("busy pin", 8'h01, {7'h00, busy});
        rd(OFS_MEM_CTRL, 1);
        chk8("busy bit", 8'h04, rb[0] & 8'h04);
        rd(OFS_EE_RDATA, 1);
        chk8("eeprom refused", 8'h00, rb[0]);
        wait_idle();
        rd(OFS_PROG_COUNT, 1);
        c1 = rb[0];
        w1(OFS_PROG_COUNT, ~c1);
        rd(OFS_PROG_COUNT, 1);
        chk8("count ro", c1, rb[0]);
        w1(OFS_UNLOCK, 8'h00);
        mem(OFS_EE_RDATA, 8'h00, 8, 1'b0);
        for (int i = 0; i < 8; i++) chk8("eeprom", img[i], rb[i]);
        rd(OFS_MEM_ADDR, 1);
        chk8("mem addr", 8'h08, rb[0]);
        // a second completed cycle bumps the count by one
        w1(OFS_UNLOCK, UNLOCK_VALUE);
        w1(OFS_MEM_CTRL, 8'h01);
        wait_idle();
        rd(OFS_PROG_COUNT, 1);
        chk8("count", c1 + 8'h01, rb[0]);
        rd(OFS_UNLOCK, 1);
        chk8("key", UNLOCK_VALUE, rb[0]);
        // reset reloads registers from eeprom; slow controller this time
        do_reset();
        m.slow_ticks = 6;
        rd(8'h00, 8);
        for (int i = 0; i < 8; i++) chk8("reload", img[i], rb[i]);
        wrap_up();
    end
    // hang guard, well above the expected run length
    initial begin
        repeat (95000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
